// ==== pkg/ram_block_pkg.sv ====
/*
 * Shared types and constants for the configurable embedded RAM block.
 * Assumes every file that needs them imports this package.
 */
`default_nettype none

package ram_block_pkg;

    // ------------------------------------------------------------
    // Block sizes and port modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SIZE_SMALL = 2'h0,
        SIZE_MEDIUM = 2'h1,
        SIZE_LARGE = 2'h3
    } size_t;

    typedef enum logic [1:0] {
        MODE_SINGLE = 2'h0,
        MODE_SIMPLE = 2'h1,
        MODE_TRUE = 2'h3,
        MODE_SPLIT = 2'h2
    } mode_t;

    // ------------------------------------------------------------
    // Capacities in bits, parity positions included
    // ------------------------------------------------------------
    localparam int BITS_SMALL = 576;
    localparam int BITS_MEDIUM = 4608;
    localparam int BITS_LARGE = 589824;

    // One lane is a byte plus its parity bit
    localparam int LANE_W = 9;

    // Value of a cleared output bit, and of an undefined read bit
    localparam logic CLR_BIT = 1'b0;
    localparam logic UNDEF_BIT = 1'b1;

    function automatic int size_bits(size_t s);
        return (s == SIZE_SMALL) ? BITS_SMALL :
               (s == SIZE_MEDIUM) ? BITS_MEDIUM : BITS_LARGE;
    endfunction : size_bits

    function automatic int lanes(int w);
        return (w + LANE_W - 1) / LANE_W;
    endfunction : lanes

endpackage : ram_block_pkg

`default_nettype wire

// ==== src/ram_array.sv ====
/*
 * Bit-addressed storage array with two write ports and two read ports
 * of independent widths and per-lane write masks.
 * Assumes addresses stay inside TOTAL / width words.
 */
`timescale 1ns/1ps
`default_nettype none

module ram_array #(
    parameter int TOTAL = 576,
    parameter int W_A = 18,
    parameter int W_B = 18,
    parameter int AW_A = 5,
    parameter int AW_B = 5,
    parameter int BE_A = 2,
    parameter int BE_B = 2
) (
    // Clock
    input wire logic clk_sys,
    // Write side, port A
    input wire logic wr_a_en,
    input wire logic [AW_A-1:0] wr_a_addr,
    input wire logic [W_A-1:0] wr_a_data,
    input wire logic [BE_A-1:0] wr_a_be,
    // Write side, port B
    input wire logic wr_b_en,
    input wire logic [AW_B-1:0] wr_b_addr,
    input wire logic [W_B-1:0] wr_b_data,
    input wire logic [BE_B-1:0] wr_b_be,
    // Read side
    input wire logic [AW_A-1:0] rd_a_addr,
    input wire logic [AW_B-1:0] rd_b_addr,
    output logic [W_A-1:0] rd_a_data,
    output logic [W_B-1:0] rd_b_data
);
    import ram_block_pkg::*;

    // Contents are not reset: the array powers up undefined
    logic [TOTAL-1:0] mem_ff;

    // Port B is applied last, so it wins on bits both ports write
    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < W_A; i++) begin
            if (wr_a_en && wr_a_be[i / LANE_W]) begin
                mem_ff[int'(wr_a_addr) * W_A + i] <= wr_a_data[i];
            end
        end
        for (int j = 0; j < W_B; j++) begin
            if (wr_b_en && wr_b_be[j / LANE_W]) begin
                mem_ff[int'(wr_b_addr) * W_B + j] <= wr_b_data[j];
            end
        end
    end

    assign rd_a_data = mem_ff[int'(rd_a_addr) * W_A +: W_A];
    assign rd_b_data = mem_ff[int'(rd_b_addr) * W_B +: W_B];

endmodule : ram_array

`default_nettype wire

// ==== src/ram_out_stage.sv ====
/*
 * Output register with bypass and an immediate-acting clear.
 * Assumes the clear and bypass come from logic on clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none

module ram_out_stage #(
    parameter int W = 18,
    parameter bit DO_RESET = 1'b1
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Data
    input wire logic [W-1:0] d,
    input wire logic load,
    input wire logic bypass,
    input wire logic clr,
    output logic [W-1:0] q
);
    import ram_block_pkg::*;

    logic [W-1:0] q_ff;
    logic [W-1:0] nxt_q;

    assign nxt_q = clr ? {W{CLR_BIT}} : (load ? d : q_ff);

    // Large blocks skip the reset, so their outputs power up unknown
    always_ff @(posedge clk_sys) begin
        if (rst && DO_RESET) begin
            q_ff <= {W{CLR_BIT}};
        end else begin
            q_ff <= nxt_q;
        end
    end

    // Clear masks the register at once, before the edge lands
    assign q = bypass ? d : (clr ? {W{CLR_BIT}} : q_ff);

endmodule : ram_out_stage

`default_nettype wire

// ==== src/cfg_ram_block.sv ====
/*
 * Configurable embedded RAM block: single-port, simple dual-port,
 * true dual-port and split single-port modes, mixed port widths,
 * parity lanes, byte enables, output bypass and register clears.
 * Assumes both ports are driven by user logic on clk_sys.
 */
// Functional notes
// - Inputs registered; reads optionally pipelined
// - Medium and large offer true dual-port
// - Simple dual-port collision: old or undefined
// - Single-port shows written data on output
// - Medium block hosts two half-size memories
// - Ports may differ in data width
// - Write strobe generated internally from clock
// - Output registers may be bypassed
// - Small/medium simple dual-port flow-through reads
// - Input clear acts; output follows next edge
// - Output clear shows at once on outputs not bypassed
// - Large block clears output registers only
// - Each byte carries one parity bit
// - Medium/large byte enables mask written bytes
// - Small block write registers share one clock
`timescale 1ns/1ps
`default_nettype none

module cfg_ram_block #(
    parameter ram_block_pkg::size_t SIZE = ram_block_pkg::SIZE_SMALL,
    parameter int W_A = 18,
    parameter int W_B = 18,
    parameter int TOTAL = ram_block_pkg::size_bits(SIZE),
    parameter int AW_A = $clog2(TOTAL / W_A),
    parameter int AW_B = $clog2(TOTAL / W_B),
    parameter int BE_A = ram_block_pkg::lanes(W_A),
    parameter int BE_B = ram_block_pkg::lanes(W_B)
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Configuration
    input wire ram_block_pkg::mode_t mode,
    input wire logic out_bypass,
    input wire logic flow_thru,
    input wire logic rdw_old,
    // Clears
    input wire logic in_clr,
    input wire logic out_clr,
    // Port A
    input wire logic [AW_A-1:0] a_addr,
    input wire logic [W_A-1:0] a_wdata,
    input wire logic [BE_A-1:0] a_be,
    input wire logic a_we,
    input wire logic a_re,
    output logic [W_A-1:0] a_q,
    // Port B
    input wire logic [AW_B-1:0] b_addr,
    input wire logic [W_B-1:0] b_wdata,
    input wire logic [BE_B-1:0] b_be,
    input wire logic b_we,
    input wire logic b_re,
    output logic [W_B-1:0] b_q
);
    import ram_block_pkg::*;

    // ------------------------------------------------------------
    // Size-dependent features
    // ------------------------------------------------------------
    localparam bit HAS_IN_CLR = (SIZE != SIZE_LARGE);
    localparam bit HAS_BE = (SIZE != SIZE_SMALL);
    localparam bit HAS_FLOW = (SIZE != SIZE_LARGE);
    localparam logic [31:0] WA32 = 32'(W_A);
    localparam logic [31:0] WB32 = 32'(W_B);

    // ------------------------------------------------------------
    // Mode resolution
    // ------------------------------------------------------------
    mode_t eff_mode;
    logic single_like;
    logic split_on;
    logic simple_on;
    logic flow_on;
    logic b_wr_ok;

    // Small has no true dual-port; split exists only in medium
    assign eff_mode = (SIZE == SIZE_SMALL && mode inside {MODE_TRUE,
        MODE_SPLIT}) ? MODE_SIMPLE :
        (SIZE == SIZE_LARGE && mode == MODE_SPLIT) ? MODE_SINGLE :
        mode;
    assign split_on = (eff_mode == MODE_SPLIT);
    assign simple_on = (eff_mode == MODE_SIMPLE);
    assign single_like = (eff_mode == MODE_SINGLE) || split_on;
    assign b_wr_ok = (eff_mode == MODE_TRUE) || split_on;
    assign flow_on = HAS_FLOW && flow_thru && simple_on;

    // ------------------------------------------------------------
    // Input registers
    // ------------------------------------------------------------
    logic in_clr_eff;
    logic [AW_A-1:0] a_addr_ff;
    logic [W_A-1:0] a_wdata_ff;
    logic [BE_A-1:0] a_be_ff;
    logic a_we_ff;
    logic a_re_ff;
    logic [AW_B-1:0] b_addr_ff;
    logic [W_B-1:0] b_wdata_ff;
    logic [BE_B-1:0] b_be_ff;
    logic b_we_ff;
    logic b_re_ff;

    assign in_clr_eff = HAS_IN_CLR && in_clr;

    // One clock captures write enable, data and address together
    always_ff @(posedge clk_sys) begin
        if (rst || in_clr_eff) begin
            a_addr_ff <= '0;
            a_wdata_ff <= '0;
            a_be_ff <= '0;
            a_we_ff <= 1'b0;
            a_re_ff <= 1'b0;
            b_addr_ff <= '0;
            b_wdata_ff <= '0;
            b_be_ff <= '0;
            b_we_ff <= 1'b0;
            b_re_ff <= 1'b0;
        end else begin
            a_addr_ff <= a_addr;
            a_wdata_ff <= a_wdata;
            a_be_ff <= a_be;
            a_we_ff <= a_we;
            a_re_ff <= a_re;
            b_addr_ff <= b_addr;
            b_wdata_ff <= b_wdata;
            b_be_ff <= b_be;
            b_we_ff <= b_we;
            b_re_ff <= b_re;
        end
    end

    // ------------------------------------------------------------
    // Address mapping and write strobes
    // ------------------------------------------------------------
    logic [AW_A-1:0] a_map;
    logic [AW_B-1:0] b_raw;
    logic [AW_B-1:0] b_map;
    logic [BE_A-1:0] a_be_eff;
    logic [BE_B-1:0] b_be_eff;
    logic wr_a;
    logic wr_b;
    logic b_re_now;

    // In split mode A owns the lower half and B the upper half
    assign a_map = split_on ?
        {1'b0, a_addr_ff[AW_A-2:0]} : a_addr_ff;
    // Flow-through takes the read address straight from the port
    assign b_raw = flow_on ? b_addr : b_addr_ff;
    assign b_map = split_on ? {1'b1, b_raw[AW_B-2:0]} : b_raw;
    assign b_re_now = flow_on ? b_re : b_re_ff;

    assign a_be_eff = HAS_BE ? a_be_ff : '1;
    assign b_be_eff = HAS_BE ? b_be_ff : '1;

    // Strobes come from registered enables, so no pulse shaping
    // is needed outside; a live input clear blocks the write
    assign wr_a = a_we_ff && !in_clr_eff;
    assign wr_b = b_we_ff && b_wr_ok && !in_clr_eff;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [W_A-1:0] rd_a;
    logic [W_B-1:0] rd_b;

    // Each port keeps its own width over one bit array
    ram_array #(
        .TOTAL(TOTAL),
        .W_A(W_A),
        .W_B(W_B),
        .AW_A(AW_A),
        .AW_B(AW_B),
        .BE_A(BE_A),
        .BE_B(BE_B)
    ) u_array (
        .clk_sys(clk_sys),
        .wr_a_en(wr_a),
        .wr_a_addr(a_map),
        .wr_a_data(a_wdata_ff),
        .wr_a_be(a_be_eff),
        .wr_b_en(wr_b),
        .wr_b_addr(b_map),
        .wr_b_data(b_wdata_ff),
        .wr_b_be(b_be_eff),
        .rd_a_addr(a_map),
        .rd_b_addr(b_map),
        .rd_a_data(rd_a),
        .rd_b_data(rd_b)
    );

    // ------------------------------------------------------------
    // Read data selection
    // ------------------------------------------------------------
    logic [31:0] a_lo;
    logic [31:0] b_lo;
    logic collide;
    logic [W_A-1:0] a_sel;
    logic [W_B-1:0] b_sel;
    logic a_load;
    logic b_load;

    assign a_lo = 32'(a_map) * WA32;
    assign b_lo = 32'(b_map) * WB32;
    // Bit ranges overlap: the read is racing the write
    assign collide = simple_on && wr_a && b_re_now &&
        (a_lo < b_lo + WB32) && (b_lo < a_lo + WA32);

    // The array is read before the edge that writes it, so old data
    // is what comes out unless undefined bits are chosen
    assign b_sel = (split_on && b_we_ff) ? b_wdata_ff :
        (collide && !rdw_old) ? {W_B{UNDEF_BIT}} : rd_b;

    // A write in single-port use is what the output shows; a write
    // wins if the user breaks the no-simultaneous-access contract
    assign a_sel = (single_like && a_we_ff) ? a_wdata_ff : rd_a;

    assign a_load = a_re_ff || (single_like && a_we_ff);
    assign b_load = b_re_now || (split_on && b_we_ff);

    // ------------------------------------------------------------
    // Output stages
    // ------------------------------------------------------------
    ram_out_stage #(
        .W(W_A),
        .DO_RESET(SIZE != SIZE_LARGE)
    ) u_out_a (
        .clk_sys(clk_sys),
        .rst(rst),
        .d(a_sel),
        .load(a_load),
        .bypass(out_bypass),
        .clr(out_clr),
        .q(a_q)
    );

    ram_out_stage #(
        .W(W_B),
        .DO_RESET(SIZE != SIZE_LARGE)
    ) u_out_b (
        .clk_sys(clk_sys),
        .rst(rst),
        .d(b_sel),
        .load(b_load),
        .bypass(out_bypass || flow_on),
        .clr(out_clr),
        .q(b_q)
    );

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    small_no_true_a: assert property (
        SIZE == SIZE_SMALL |-> eff_mode inside {MODE_SINGLE, MODE_SIMPLE})
        else $error("small block entered a dual-write mode");

    rdw_undef_a: assert property (
        collide && !rdw_old && !out_clr
        |=> out_bypass || flow_on || out_clr || b_q == {W_B{UNDEF_BIT}})
        else $error("collision read not flagged undefined");

    write_through_a: assert property (
        single_like && a_we_ff && out_bypass |-> a_q == a_wdata_ff)
        else $error("single-port output missed written data");

    reg_delay_a: assert property (
        !out_bypass && !out_clr && a_load ##1 !out_clr && !out_bypass
        |-> a_q == $past(a_sel))
        else $error("registered output not one edge late");

    split_half_a: assert property (
        split_on |-> !a_map[AW_A-1] && b_map[AW_B-1])
        else $error("split halves overlap");

    flow_now_a: assert property (
        flow_on && b_re && !collide |-> b_q == rd_b && b_map == b_addr)
        else $error("flow-through read not combinational");

    in_clr_a: assert property (
        in_clr_eff |-> !wr_a ##1 a_addr_ff == '0 && !a_we_ff)
        else $error("input clear did not clear inputs");

    out_clr_a: assert property (
        out_clr && !out_bypass |-> a_q == '0)
        else $error("output clear not immediate");

    large_clr_a: assert property (
        SIZE == SIZE_LARGE && a_we_ff |-> wr_a)
        else $error("large block honoured an input clear");

    be_small_a: assert property (
        SIZE == SIZE_SMALL |-> a_be_eff == '1 && b_be_eff == '1)
        else $error("small block applied byte masks");

    collide_c: cover property (collide);
    flow_c: cover property (flow_on && b_re);
    split_c: cover property (split_on && wr_a && wr_b);
    true_c: cover property (eff_mode == MODE_TRUE && wr_a && wr_b);

endmodule : cfg_ram_block

`default_nettype wire

// ==== tb/fabric_user.sv ====
/*
 * Model of the fabric user logic that drives both request ports.
 * Assumes a medium block with a 9-bit port A and an 18-bit port B.
 */
`timescale 1ns/1ps
`default_nettype none

module fabric_user #(
    parameter int AW_A = 9,
    parameter int AW_B = 8
) (
    // Clock
    input wire logic clk_sys,
    // Port A requests
    output logic [AW_A-1:0] a_addr,
    output logic [8:0] a_wdata,
    output logic [0:0] a_be,
    output logic a_we,
    output logic a_re,
    // Port B requests
    output logic [AW_B-1:0] b_addr,
    output logic [17:0] b_wdata,
    output logic [1:0] b_be,
    output logic b_we,
    output logic b_re
);
    // Once set, writes stay off so the array behaves as a ROM
    logic rom_lock = 1'b0;

    initial begin
        {a_addr, a_wdata, a_we, a_re} = '0;
        {b_addr, b_wdata, b_be, b_we, b_re} = '0;
        a_be = 1'h1;
    end

    // ------------------------------------------------------------
    // One request per port, held over the capturing rising edge
    // ------------------------------------------------------------
    task automatic issue(input logic wa, ra, input logic [AW_A-1:0] aa,
            input logic [8:0] da, input logic wb, rb,
            input logic [AW_B-1:0] ab, input logic [17:0] db,
            input logic [1:0] bb);
        @(negedge clk_sys);
        a_we = wa & ~rom_lock;
        a_re = ra & ~wa;
        a_addr = aa;
        a_wdata = da;
        b_we = wb & ~rom_lock;
        b_re = rb & ~wb;
        b_addr = ab;
        b_wdata = db;
        b_be = bb;
        @(negedge clk_sys);
        a_we = 1'b0;
        a_re = 1'b0;
        b_we = 1'b0;
        b_re = 1'b0;
        // Released lines flip so a stale value never passes for data
        a_addr = ~a_addr;
        a_wdata = ~a_wdata;
        b_addr = ~b_addr;
        b_wdata = ~b_wdata;
    endtask : issue

endmodule : fabric_user
`default_nettype wire

// ==== tb/cfg_ram_block_tb_top.sv ====
/*
 * Self-checking testbench for a medium cfg_ram_block, 9-bit port A and
 * 18-bit port B.
 * Assumes fabric_user drives the request ports on falling edges.
 */
`timescale 1ns/1ps
`default_nettype none

module cfg_ram_block_tb_top;
    import ram_block_pkg::*;

    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    mode_t mode = MODE_SIMPLE;
    logic out_bypass = 1'b0;
    logic flow_thru = 1'b0;
    logic rdw_old = 1'b1;
    logic in_clr = 1'b0;
    logic out_clr = 1'b0;
    logic [8:0] a_addr, a_wdata, a_q;
    logic [0:0] a_be;
    logic a_we, a_re, b_we, b_re;
    logic [7:0] b_addr;
    logic [17:0] b_wdata, b_q;
    logic [1:0] b_be;
    int err_count = 0;
    int n_tests = 0;

    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end

    // ------------------------------------------------------------
    // Block and user logic
    // ------------------------------------------------------------
    cfg_ram_block #(.SIZE(SIZE_MEDIUM), .W_A(9), .W_B(18)) u_cfg_ram_block (
        .clk_sys(clk_sys), .rst(rst), .mode(mode), .out_bypass(out_bypass),
        .flow_thru(flow_thru), .rdw_old(rdw_old), .in_clr(in_clr),
        .out_clr(out_clr), .a_addr(a_addr), .a_wdata(a_wdata), .a_be(a_be),
        .a_we(a_we), .a_re(a_re), .a_q(a_q), .b_addr(b_addr),
        .b_wdata(b_wdata), .b_be(b_be), .b_we(b_we), .b_re(b_re), .b_q(b_q)
    );

    fabric_user u_fabric_user (
        .clk_sys(clk_sys), .a_addr(a_addr), .a_wdata(a_wdata), .a_be(a_be),
        .a_we(a_we), .a_re(a_re), .b_addr(b_addr), .b_wdata(b_wdata),
        .b_be(b_be), .b_we(b_we), .b_re(b_re)
    );

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [17:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test

    task automatic go(input logic wa, ra, input logic [8:0] aa, da,
            input logic wb, rb, input logic [7:0] ab,
            input logic [17:0] db, input logic [1:0] bb);
        u_fabric_user.issue(wa, ra, aa, da, wb, rb, ab, db, bb);
    endtask : go

    // ------------------------------------------------------------
    // Scenarios; each returns at a falling edge
    // ------------------------------------------------------------
    task automatic t_mixed;
        check("a_q after reset", {9'h0, a_q}, 18'h0);
        check("b_q after reset", b_q, 18'h0);
        go(1'h1, 1'h0, 9'h004, 9'h0a5, 1'h0, 1'h0, 8'h00, 18'h0, 2'h0);
        go(1'h1, 1'h0, 9'h005, 9'h15a, 1'h0, 1'h0, 8'h00, 18'h0, 2'h0);
        go(1'h0, 1'h0, 9'h000, 9'h000, 1'h0, 1'h1, 8'h02, 18'h0, 2'h0);
        check("b_q before output edge", b_q, 18'h0);
        @(negedge clk_sys);
        check("b_q mixed width", b_q, 18'h2b4a5);
        $display("test mixed width done");
    endtask : t_mixed

    task automatic t_clears;
        out_clr = 1'b1;
        // No clock edge in between: the clear must act by itself
        #1;
        check("b_q output clear", b_q, 18'h0);
        @(negedge clk_sys);
        out_clr = 1'b0;
        in_clr = 1'b1;
        go(1'h1, 1'h0, 9'h004, 9'h000, 1'h0, 1'h0, 8'h00, 18'h0, 2'h0);
        in_clr = 1'b0;
        out_bypass = 1'b1;
        go(1'h0, 1'h0, 9'h000, 9'h000, 1'h0, 1'h1, 8'h02, 18'h0, 2'h0);
        check("write under input clear", b_q, 18'h2b4a5);
        out_bypass = 1'b0;
        $display("test clears and bypass done");
    endtask : t_clears

    task automatic t_collide;
        go(1'h1, 1'h0, 9'h004, 9'h033, 1'h0, 1'h1, 8'h02, 18'h0, 2'h0);
        @(negedge clk_sys);
        check("collision old data", b_q, 18'h2b4a5);
        rdw_old = 1'b0;
        go(1'h1, 1'h0, 9'h004, 9'h044, 1'h0, 1'h1, 8'h02, 18'h0, 2'h0);
        @(negedge clk_sys);
        check("collision undefined", {9'h0, b_q[8:0]}, 18'h001ff);
        rdw_old = 1'b1;
        $display("test collision done");
    endtask : t_collide

    task automatic t_true;
        mode = MODE_TRUE;
        go(1'h0, 1'h0, 9'h000, 9'h000, 1'h1, 1'h0, 8'h03, 18'h3ffff, 2'h3);
        go(1'h1, 1'h0, 9'h008, 9'h1ff, 1'h1, 1'h0, 8'h03, 18'h0, 2'h1);
        go(1'h0, 1'h1, 9'h007, 9'h000, 1'h0, 1'h1, 8'h03, 18'h0, 2'h0);
        @(negedge clk_sys);
        check("masked lane kept", {9'h0, a_q}, 18'h001ff);
        check("lane written", b_q, 18'h3fe00);
        $display("test true dual-port done");
    endtask : t_true

    task automatic t_single;
        mode = MODE_SINGLE;
        out_bypass = 1'b1;
        go(1'h1, 1'h0, 9'h009, 9'h1c3, 1'h0, 1'h0, 8'h00, 18'h0, 2'h0);
        check("write-through bypassed", {9'h0, a_q}, 18'h001c3);
        out_bypass = 1'b0;
        go(1'h1, 1'h0, 9'h009, 9'h03c, 1'h0, 1'h0, 8'h00, 18'h0, 2'h0);
        @(negedge clk_sys);
        check("write-through registered", {9'h0, a_q}, 18'h0003c);
        mode = MODE_SPLIT;
        go(1'h1, 1'h0, 9'h000, 9'h0c5, 1'h1, 1'h0, 8'h00, 18'h2aaaa, 2'h3);
        go(1'h0, 1'h1, 9'h000, 9'h000, 1'h0, 1'h1, 8'h00, 18'h0, 2'h0);
        @(negedge clk_sys);
        check("split lower half", {9'h0, a_q}, 18'h000c5);
        check("split upper half", b_q, 18'h2aaaa);
        $display("test single and split done");
    endtask : t_single

    task automatic t_flow;
        mode = MODE_SIMPLE;
        flow_thru = 1'b1;
        fork
            go(1'h0, 1'h0, 9'h000, 9'h000, 1'h0, 1'h1, 8'h03, 18'h0, 2'h0);
            begin
                @(negedge clk_sys);
                #1;
                check("flow-through read", b_q, 18'h3fe00);
            end
        join
        flow_thru = 1'b0;
        mode = MODE_TRUE;
        u_fabric_user.rom_lock = 1'b1;
        go(1'h0, 1'h0, 9'h000, 9'h000, 1'h1, 1'h0, 8'h03, 18'h0, 2'h3);
        go(1'h0, 1'h0, 9'h000, 9'h000, 1'h0, 1'h1, 8'h03, 18'h0, 2'h0);
        @(negedge clk_sys);
        check("contents after lock", b_q, 18'h3fe00);
        $display("test flow-through and lock done");
    endtask : t_flow

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(negedge clk_sys);
        rst = 1'b0;
        @(negedge clk_sys);
        t_mixed;
        t_clears;
        t_collide;
        t_true;
        t_single;
        t_flow;
        stop_test;
    end

    initial begin
        repeat (2000) @(posedge clk_sys);
        err_count++;
        $display("Error watchdog expected end seen hang");
        stop_test;
    end

endmodule : cfg_ram_block_tb_top
`default_nettype wire
